// File: plc_pkg.sv
package plc_pkg;
	localparam int DW = 16;
	localparam int FRAC = 14;
	localparam int AW = 5;
	localparam logic signed [15:0] ONE = 16'sh4000;
	localparam logic signed [15:0] ZERO = 16'sh0000;
	localparam logic [15:0] TI_DISABLE = 16'h270F;
	localparam logic [15:0] BCD_MAX = 16'h4095;

	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_TARGET = 5'h01;
	localparam logic [4:0] REG_GAIN = 5'h02;
	localparam logic [4:0] REG_SAMPLE = 5'h03;
	localparam logic [4:0] REG_RESET_T = 5'h04;
	localparam logic [4:0] REG_RATE_T = 5'h05;
	localparam logic [4:0] REG_BIAS = 5'h06;
	localparam logic [4:0] REG_MANUAL = 5'h07;
	localparam logic [4:0] REG_OUT_MIN = 5'h08;
	localparam logic [4:0] REG_OUT_MAX = 5'h09;
	localparam logic [4:0] REG_LIM_HH = 5'h0A;
	localparam logic [4:0] REG_LIM_H = 5'h0B;
	localparam logic [4:0] REG_LIM_L = 5'h0C;
	localparam logic [4:0] REG_LIM_LL = 5'h0D;
	localparam logic [4:0] REG_DEV_MINOR = 5'h0E;
	localparam logic [4:0] REG_DEV_MAJOR = 5'h0F;
	localparam logic [4:0] REG_RATE_LIM = 5'h10;
	localparam logic [4:0] REG_HYST = 5'h11;
	localparam logic [4:0] REG_STATUS = 5'h12;
	localparam logic [4:0] REG_OUTPUT = 5'h13;
	localparam logic [4:0] REG_DELTA = 5'h14;
	localparam logic [4:0] REG_COEF_I = 5'h15;
	localparam logic [4:0] REG_COEF_D = 5'h16;

	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_VEL_BIT = 2;
	localparam int CTRL_FREEZE_BIT = 3;
	localparam int CTRL_STEP_BIT = 4;
	localparam int CTRL_REV_BIT = 5;
	localparam int CTRL_XFER2_BIT = 6;

	localparam int ALM_ROC = 4;
	localparam int ALM_MINOR = 5;
	localparam int ALM_MAJOR = 6;

	typedef enum logic [1:0] {MODE_MANUAL, MODE_AUTO, MODE_CASCADE, MODE_BAD} plc_mode_t;

	function automatic logic signed [15:0] plc_sat(input logic signed [31:0] v);
		if (v > 32'sh00007FFF) return 16'sh7FFF;
		if (v < -32'sh00008000) return -16'sh8000;
		return v[15:0];
	endfunction

	function automatic logic signed [15:0] plc_clamp01(input logic signed [31:0] v);
		if (v < 32'sh0) return ZERO;
		if (v > 32'sh00004000) return ONE;
		return v[15:0];
	endfunction

	function automatic logic [11:0] plc_bcd2bin(input logic [15:0] b);
		logic [15:0] s;
		s = 16'(b[15:12]) * 16'd1000 + 16'(b[11:8]) * 16'd100 + 16'(b[7:4]) * 16'd10 + 16'(b[3:0]);
		return s[11:0];
	endfunction
endpackage

// File: plc_pid_loop.sv
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
// How it works
// - Position form: error, accumulated bias, output.
// - Derivative acts on measured value difference.
// - Coefficients include gain unless gain zero.
// - Output clamped to nearer of 0, 1.
// - Programmable BCD output limits, 0 to 4095.
// - Bias never below 0 or above 1.
// - Freeze keeps previous bias when out of range.
// - Default recomputes bias from clamped output.
// - Setpoint step scales bias by ratio, clamped.
// - Reset period 9999 disables integral action.
// - Rate period zero gives zero derivative coefficient.
// - Velocity form outputs change between samples.
// - Manual to automatic: target follows unless xfer2 set, bias follows unless velocity form.
// - Two selectable bumpless transfer variants.
// - Four measured value limit alarms.
// - Minor and major deviation alarms, both directions.
// - Rate of change alarm between samples.
// - Alarms set past threshold, with hysteresis except rate of change.
// - Exactly one of manual, automatic, cascade.
// - Manual passes operator output, alarms still run.
// - Automatic computes output each sample.
// - Cascade takes target from another loop.
// - Reverse acting negates proportional and integral parts.
module plc_pid_loop (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic sample_tick,
	input wire logic signed [plc_pkg::DW-1:0] measured_value,
	input wire logic signed [plc_pkg::DW-1:0] cascade_target,
	input wire logic [plc_pkg::AW-1:0] reg_addr,
	input wire logic [plc_pkg::DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [plc_pkg::DW-1:0] reg_rdata,
	output logic signed [plc_pkg::DW-1:0] control_out,
	output logic signed [plc_pkg::DW-1:0] control_delta,
	output logic [11:0] output_code,
	output logic [6:0] alarm_flags
);
	import plc_pkg::*;

	typedef struct packed {
		plc_mode_t mode;
		logic vel;
		logic freeze;
		logic step_en;
		logic rev;
		logic xfer2;
		logic signed [15:0] sp;
		logic signed [15:0] gain;
		logic [15:0] ts;
		logic [15:0] ti;
		logic [15:0] td;
		logic signed [15:0] ki;
		logic signed [15:0] kr;
		logic signed [15:0] bias;
		logic signed [15:0] manual;
		logic [15:0] omin;
		logic [15:0] omax;
		logic [3:0][15:0] lim;
		logic [15:0] dev_minor;
		logic [15:0] dev_major;
		logic [15:0] rate_lim;
		logic [15:0] hyst;
		logic [6:0] alarm;
		logic signed [15:0] pv1;
		logic signed [15:0] pv2;
		logic signed [15:0] e1;
		logic signed [15:0] m;
		logic signed [15:0] dm;
		logic [11:0] code;
		logic [15:0] rdata;
	} plc_state_t;

	plc_state_t q;
	plc_state_t d;

	logic signed [31:0] sp_eff, err, dpv, d2pv, p_term, i_term, d_term, pv_term;
	logic signed [31:0] bias_acc, m_raw, dm_raw, adj, dev_abs, roc_abs, lv, thr, hy, span;
	logic signed [15:0] m_clamp, bias_new;
	logic [31:0] rat_i, rat_d, num, den;
	logic signed [31:0] ki_full, kr_full;
	logic out_rng, ti_dis, to_auto;

	always_comb begin
		d = q;
		d.rdata = 16'h0000;
		// Alarm scratch values get a value on every path so no latch is left between ticks.
		hy = 32'sh0;
		thr = 32'sh0;
		dev_abs = 32'sh0;
		roc_abs = 32'sh0;
		ti_dis = (q.ti == TI_DISABLE);
		// Cascade swaps only the target source; everything else is automatic.
		sp_eff = (q.mode == MODE_CASCADE) ? 32'(cascade_target) : 32'(q.sp);
		err = sp_eff - 32'(measured_value);
		err = 32'(plc_sat(err));

		// Coefficients are rebuilt every cycle, so a parameter write takes effect one cycle later.
		rat_i = (q.ti == 16'h0000) ? 32'h0 : {2'b00, q.ts, 14'h0} / {16'h0, q.ti};
		rat_d = (q.ts == 16'h0000) ? 32'h0 : {2'b00, q.td, 14'h0} / {16'h0, q.ts};
		if (rat_i > 32'h00007FFF) rat_i = 32'h00007FFF;
		if (rat_d > 32'h00007FFF) rat_d = 32'h00007FFF;
		if (q.gain == 16'sh0000) begin
			ki_full = $signed(rat_i);
			kr_full = $signed(rat_d);
		end else begin
			ki_full = (32'(q.gain) * $signed(rat_i)) >>> FRAC;
			kr_full = (32'(q.gain) * $signed(rat_d)) >>> FRAC;
		end
		d.ki = ti_dis ? ZERO : plc_sat(ki_full);
		d.kr = (q.td == 16'h0000) ? ZERO : plc_sat(kr_full);

		dpv = 32'(measured_value) - 32'(q.pv1);
		d2pv = dpv - 32'(q.pv1) + 32'(q.pv2);
		p_term = (32'(q.gain) * err) >>> FRAC;
		i_term = (32'(q.ki) * err) >>> FRAC;
		d_term = (32'(q.kr) * dpv) >>> FRAC;
		pv_term = (32'(q.kr) * d2pv) >>> FRAC;
		dm_raw = (32'(q.gain) * (err - 32'(q.e1))) >>> FRAC;
		if (q.rev) begin
			p_term = -p_term;
			i_term = -i_term;
			dm_raw = -dm_raw;
		end
		bias_acc = 32'(plc_clamp01(32'(q.bias) + i_term));
		m_raw = 32'(plc_sat(p_term - d_term + bias_acc));
		out_rng = (m_raw < 32'sh0) || (m_raw > 32'(ONE));
		m_clamp = plc_clamp01(m_raw);
		adj = 32'(m_clamp) - p_term - d_term;
		if (ti_dis)
			bias_new = q.bias;
		else if (!out_rng)
			bias_new = bias_acc[15:0];
		else if (q.freeze)
			bias_new = q.bias;
		else
			bias_new = plc_clamp01(adj);
		dm_raw = 32'(plc_sat(dm_raw + i_term - pv_term));

		// Scale the clamped output into the programmed output code span.
		span = $signed(32'(plc_bcd2bin(q.omax))) - $signed(32'(plc_bcd2bin(q.omin)));
		lv = $signed(32'(plc_bcd2bin(q.omin))) + ((32'(q.m) * span) >>> FRAC);
		d.code = lv[11:0];

		if (sample_tick) begin
			if (q.mode == MODE_MANUAL) begin
				d.m = q.manual;
				d.dm = plc_sat(32'(q.manual) - 32'(q.m));
			end else if (q.vel) begin
				d.dm = dm_raw[15:0];
				d.m = plc_clamp01(32'(q.m) + dm_raw);
			end else begin
				d.m = m_clamp;
				d.bias = bias_new;
				d.dm = plc_sat(32'(m_clamp) - 32'(q.m));
			end
			d.pv2 = q.pv1;
			d.pv1 = measured_value;
			d.e1 = err[15:0];

			// Alarms run in every mode; hysteresis keeps a set limit or deviation flag until the value is clearly back.
			hy = 32'(q.hyst);
			for (int i = 0; i < 4; i++) begin
				thr = 32'($signed(q.lim[i]));
				if (i < 2) begin
					if (32'(measured_value) > thr) d.alarm[i] = 1'b1;
					else if (32'(measured_value) <= thr - hy) d.alarm[i] = 1'b0;
				end else begin
					if (32'(measured_value) < thr) d.alarm[i] = 1'b1;
					else if (32'(measured_value) >= thr + hy) d.alarm[i] = 1'b0;
				end
			end
			dev_abs = (err < 32'sh0) ? -err : err;
			if (dev_abs > 32'(q.dev_minor)) d.alarm[ALM_MINOR] = 1'b1;
			else if (dev_abs <= 32'(q.dev_minor) - hy) d.alarm[ALM_MINOR] = 1'b0;
			if (dev_abs > 32'(q.dev_major)) d.alarm[ALM_MAJOR] = 1'b1;
			else if (dev_abs <= 32'(q.dev_major) - hy) d.alarm[ALM_MAJOR] = 1'b0;
			roc_abs = (dpv < 32'sh0) ? -dpv : dpv;
			d.alarm[ALM_ROC] = (roc_abs > 32'(q.rate_lim));
		end

		to_auto = 1'b0;
		num = 32'h0;
		den = 32'h0;
		if (reg_wr) begin
			case (reg_addr)
				REG_CTRL: begin
					// A mode code of 3 is ignored so the loop always sits in a legal mode.
					if (reg_wdata[CTRL_MODE_LSB+:2] != 2'd3) d.mode = plc_mode_t'(reg_wdata[CTRL_MODE_LSB+:2]);
					d.vel = reg_wdata[CTRL_VEL_BIT];
					d.freeze = reg_wdata[CTRL_FREEZE_BIT];
					d.step_en = reg_wdata[CTRL_STEP_BIT];
					d.rev = reg_wdata[CTRL_REV_BIT];
					d.xfer2 = reg_wdata[CTRL_XFER2_BIT];
					to_auto = (q.mode == MODE_MANUAL) && (reg_wdata[CTRL_MODE_LSB+:2] == 2'd1 ||
						reg_wdata[CTRL_MODE_LSB+:2] == 2'd2);
					if (to_auto) begin
						if (!reg_wdata[CTRL_XFER2_BIT]) d.sp = q.pv1;
						if (!reg_wdata[CTRL_VEL_BIT]) d.bias = q.m;
					end
				end
				REG_TARGET: begin
					d.sp = reg_wdata;
					if (q.step_en) begin
						num = q.rev ? {16'h0, q.sp} : {16'h0, reg_wdata};
						den = q.rev ? {16'h0, reg_wdata} : {16'h0, q.sp};
						if (den != 32'h0 && !num[15] && !den[15])
							d.bias = plc_clamp01($signed(({16'h0, q.bias} * num) / den));
					end
				end
				REG_GAIN: d.gain = reg_wdata;
				REG_SAMPLE: d.ts = reg_wdata;
				REG_RESET_T: d.ti = reg_wdata;
				REG_RATE_T: d.td = reg_wdata;
				REG_BIAS: d.bias = plc_clamp01(32'($signed(reg_wdata)));
				REG_MANUAL: d.manual = plc_clamp01(32'($signed(reg_wdata)));
				REG_OUT_MIN: d.omin = (reg_wdata > BCD_MAX) ? BCD_MAX : reg_wdata;
				REG_OUT_MAX: d.omax = (reg_wdata > BCD_MAX) ? BCD_MAX : reg_wdata;
				REG_LIM_HH: d.lim[0] = reg_wdata;
				REG_LIM_H: d.lim[1] = reg_wdata;
				REG_LIM_L: d.lim[2] = reg_wdata;
				REG_LIM_LL: d.lim[3] = reg_wdata;
				REG_DEV_MINOR: d.dev_minor = reg_wdata;
				REG_DEV_MAJOR: d.dev_major = reg_wdata;
				REG_RATE_LIM: d.rate_lim = reg_wdata;
				REG_HYST: d.hyst = reg_wdata;
				default: ;
			endcase
		end

		if (reg_rd) begin
			case (reg_addr)
				REG_CTRL: d.rdata = {9'h0, q.xfer2, q.rev, q.step_en, q.freeze, q.vel, q.mode};
				REG_TARGET: d.rdata = q.sp;
				REG_GAIN: d.rdata = q.gain;
				REG_SAMPLE: d.rdata = q.ts;
				REG_RESET_T: d.rdata = q.ti;
				REG_RATE_T: d.rdata = q.td;
				REG_BIAS: d.rdata = q.bias;
				REG_MANUAL: d.rdata = q.manual;
				REG_OUT_MIN: d.rdata = q.omin;
				REG_OUT_MAX: d.rdata = q.omax;
				REG_LIM_HH: d.rdata = q.lim[0];
				REG_LIM_H: d.rdata = q.lim[1];
				REG_LIM_L: d.rdata = q.lim[2];
				REG_LIM_LL: d.rdata = q.lim[3];
				REG_DEV_MINOR: d.rdata = q.dev_minor;
				REG_DEV_MAJOR: d.rdata = q.dev_major;
				REG_RATE_LIM: d.rdata = q.rate_lim;
				REG_HYST: d.rdata = q.hyst;
				REG_STATUS: d.rdata = {9'h0, q.alarm};
				REG_OUTPUT: d.rdata = q.m;
				REG_DELTA: d.rdata = q.dm;
				REG_COEF_I: d.rdata = q.ki;
				REG_COEF_D: d.rdata = q.kr;
				default: d.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata = q.rdata;
	assign control_out = q.m;
	assign control_delta = q.dm;
	assign output_code = q.code;
	assign alarm_flags = q.alarm;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	sequence s_auto_tick;
		sample_tick && !reg_wr && q.mode != MODE_MANUAL;
	endsequence

	property p_out_range;
		q.m >= ZERO && q.m <= ONE;
	endproperty
	a_out_range: assert property (p_out_range) else $error("control output left 0..1");

	property p_bias_range;
		q.bias >= ZERO && q.bias <= ONE;
	endproperty
	a_bias_range: assert property (p_bias_range) else $error("bias left 0..1");

	property p_manual_pass;
		sample_tick && q.mode == MODE_MANUAL |=> q.m == $past(q.manual);
	endproperty
	a_manual_pass: assert property (p_manual_pass) else $error("manual output not passed");

	property p_roc;
		sample_tick && (measured_value - q.pv1 > $signed({1'b0, q.rate_lim[14:0]})) |=> q.alarm[ALM_ROC];
	endproperty
	a_roc: assert property (p_roc) else $error("rate alarm missed");

	property p_ti_disable;
		s_auto_tick and (q.ti == TI_DISABLE && !q.vel) |=> $stable(q.bias);
	endproperty
	a_ti_disable: assert property (p_ti_disable) else $error("bias moved with integral off");

	property p_td_zero;
		q.td == 16'h0000 && !reg_wr |=> q.kr == ZERO;
	endproperty
	a_td_zero: assert property (p_td_zero) else $error("derivative coefficient not zero");

	property p_hold_history;
		!sample_tick |=> $stable(q.pv1) && $stable(q.pv2) && $stable(q.e1);
	endproperty
	a_hold_history: assert property (p_hold_history) else $error("history changed without tick");

	property p_transfer;
		reg_wr && reg_addr == REG_CTRL && q.mode == MODE_MANUAL && reg_wdata[1:0] == 2'd1 &&
			!reg_wdata[CTRL_XFER2_BIT] && !sample_tick |=> q.sp == $past(q.pv1) && q.mode == MODE_AUTO;
	endproperty
	a_transfer: assert property (p_transfer) else $error("bumpless transfer target wrong");

	property p_hh_set;
		sample_tick && measured_value > $signed(q.lim[0]) |=> q.alarm[0];
	endproperty
	a_hh_set: assert property (p_hh_set) else $error("high-high alarm missed");

	property p_mode_legal;
		q.mode != MODE_BAD;
	endproperty
	a_mode_legal: assert property (p_mode_legal) else $error("illegal loop mode");

	property p_read_one;
		reg_rd && reg_addr == REG_STATUS |=> reg_rdata == {9'h0, $past(q.alarm)} ##1 reg_rdata == 16'h0000 || $past(reg_rd);
	endproperty
	a_read_one: assert property (p_read_one) else $error("status read data wrong");

	sequence s_vel_tick;
		s_auto_tick ##0 q.vel;
	endsequence

	sequence s_pos_tick;
		s_auto_tick ##0 !q.vel;
	endsequence

	property p_vel_accum;
		s_vel_tick |=> q.m == plc_clamp01(32'($past(q.m)) + 32'(q.dm));
	endproperty
	a_vel_accum: assert property (p_vel_accum) else $error("velocity output did not accumulate delta");

	property p_pos_delta;
		s_pos_tick |=> q.dm == plc_sat(32'(q.m) - 32'($past(q.m)));
	endproperty
	a_pos_delta: assert property (p_pos_delta) else $error("position delta wrong");

	property p_hold_out;
		!sample_tick |=> $stable(q.m) && $stable(q.dm) && $stable(q.alarm);
	endproperty
	a_hold_out: assert property (p_hold_out) else $error("outputs changed without tick");

	property p_hh_hold;
		sample_tick && q.alarm[0] &&
			32'(measured_value) > 32'($signed(q.lim[0])) - $signed({16'h0, q.hyst}) |=> q.alarm[0];
	endproperty
	a_hh_hold: assert property (p_hh_hold) else $error("high-high alarm cleared inside hysteresis");

	property p_major_set;
		sample_tick && (err > $signed({16'h0, q.dev_major}) || -err > $signed({16'h0, q.dev_major})) |=>
			q.alarm[ALM_MAJOR];
	endproperty
	a_major_set: assert property (p_major_set) else $error("major deviation alarm missed");

	property p_cascade_err;
		q.mode == MODE_CASCADE |-> err == 32'(plc_sat(32'(cascade_target) - 32'(measured_value)));
	endproperty
	a_cascade_err: assert property (p_cascade_err) else $error("cascade error not from cascade target");
endmodule

// File: plc_ain.sv
`timescale 1ns/1ps
// Analog input converter. The converted value shows one clock after the level is applied and holds until the next conversion.
module plc_ain (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic signed [15:0] level,
	output logic signed [15:0] measured_value
);
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			measured_value <= 16'sh0000;
		else
			measured_value <= level;
	end
endmodule

// File: pid_loop_controller_tb.sv
`timescale 1ns/1ps
module pid_loop_controller_tb;
	import plc_pkg::*;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic sample_tick = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic signed [15:0] level = 16'sh0000;
	logic signed [15:0] cascade_target = 16'sh0000;
	logic signed [15:0] measured_value, control_out, control_delta;
	logic [15:0] reg_rdata;
	logic [11:0] output_code;
	logic [6:0] alarm_flags;
	int n_fail = 0;
	int checks_done = 0;
	int cyc = 0;
	// Bench copy of the loop: written settings, history and expected outputs.
	int md = 0, vel = 0, frz = 0, stp = 0, rev = 0, tg = 0, g = 0, ts = 0, ti = 0, td = 0;
	int man = 32'h2000, mx = 0, o = 0, d = 0, p1 = 0, p2 = 0, e1 = 0, al = 0, hy = 32'h100;
	// Alarm thresholds in flag order: hh, h, l, ll, rate, minor, major.
	int lim[7] = '{32'h3000, 32'h2800, 32'h1000, 32'h0800, 32'h0300, 32'h0400, 32'h0800};
	int cg[3] = '{32'h4000, 0, 32'h4000};
	int cs[3] = '{2, 2, 5};
	int ci[3] = '{4, 4, 9999};
	int cd[3] = '{2, 0, 5};

	plc_pid_loop DUT (.mclk(mclk), .sys_rst(sys_rst), .sample_tick(sample_tick), .measured_value(measured_value),
		.cascade_target(cascade_target), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .control_out(control_out), .control_delta(control_delta),
		.output_code(output_code), .alarm_flags(alarm_flags));
	plc_ain ain (.mclk(mclk), .sys_rst(sys_rst), .level(level), .measured_value(measured_value));

	initial forever #5 mclk = ~mclk;

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	function automatic int c01(int v);
		return v < 0 ? 0 : (v > ONE ? int'(ONE) : v);
	endfunction
	function automatic int mul(int a, int b);
		return (a * b) >>> 14;
	endfunction
	function automatic int ab(int v);
		return v < 0 ? -v : v;
	endfunction
	// Gain drops out of both coefficients when it is zero.
	function automatic int kco(int p, int q);
		return (g != 0 ? g : int'(ONE)) * p / q;
	endfunction
	function automatic int rn(int lo, int w);
		return lo + int'($urandom_range(w));
	endfunction

	task automatic chk(string nm, logic [15:0] s, logic [15:0] x);
		checks_done++;
		if (s !== x) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic wr(logic [4:0] a, int v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= 16'(v);
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [4:0] a, int x);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk("rdata", reg_rdata, 16'(x));
	endtask
	task automatic par(int a, int b, int c, int e);
		g = a;
		ts = b;
		ti = c;
		td = e;
		wr(REG_GAIN, a);
		wr(REG_SAMPLE, b);
		wr(REG_RESET_T, c);
		wr(REG_RATE_T, e);
	endtask
	task automatic ctrl(int v);
		if (md == 0 && (v[1:0] == 2'b01 || v[1:0] == 2'b10)) begin
			if (!v[2]) mx = o;
			if (!v[6]) tg = p1;
		end
		if (v[1:0] != 2'b11) md = v[1:0];
		vel = v[2];
		frz = v[3];
		stp = v[4];
		rev = v[5];
		wr(REG_CTRL, v);
	endtask
	task automatic settg(int v);
		if (stp != 0 && tg > 0 && v > 0) mx = c01(rev ? mx * tg / v : mx * v / tg);
		tg = v;
		wr(REG_TARGET, v);
	endtask
	task automatic tick(int pv, int c);
		int t, e, a, m, x, s, ki, kr;
		@(posedge mclk);
		level <= 16'(pv);
		cascade_target <= 16'(c);
		@(posedge mclk);
		sample_tick <= 1'b1;
		@(posedge mclk);
		sample_tick <= 1'b0;
		t = md == 2 ? c : tg;
		e = t - pv;
		s = rev ? -1 : 1;
		if (md != 0) begin
			ki = ti == 9999 ? 0 : kco(ts, ti);
			kr = td ? kco(td, ts) : 0;
			a = mx + s * mul(ki, e);
			if (vel) begin
				d = s * (mul(g, e - e1) + mul(ki, e)) - mul(kr, pv - 2 * p1 + p2);
				o = c01(o + d);
			end else begin
				m = s * mul(g, e) - mul(kr, pv - p1) + c01(a);
				d = c01(m) - o;
				o = c01(m);
				// With integral off the bias belongs to the host, so a clamped output does not re-aim it.
				if (m == o) mx = c01(a);
				else if (frz == 0 && ti != 9999) mx = c01(o - s * mul(g, e) - mul(kr, pv - p1));
			end
		end else begin
			d = man - o;
			o = man;
		end
		e1 = e;
		for (int i = 0; i < 7; i++) begin
			x = i < 2 ? pv - lim[i] : i < 4 ? lim[i] - pv : (i == 4 ? ab(pv - p1) : ab(pv - t)) - lim[i];
			if (x > 0) al[i] = 1'b1;
			else if (i == 4 || x <= -hy) al[i] = 1'b0;
		end
		p2 = p1;
		p1 = pv;
		#1 chk("control_out", control_out, 16'(o));
		chk("alarm_flags", 16'(alarm_flags), 16'(al));
		chk("control_delta", control_delta, 16'(d));
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		void'($urandom(32'hC1F9));
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(REG_CTRL, 0);
		rd(REG_STATUS, 0);
		rd(5'h1F, 0);
		for (int i = 0; i < 3; i++) begin
			par(cg[i], cs[i], ci[i], cd[i]);
			rd(REG_COEF_I, ti == 9999 ? 0 : kco(ts, ti));
			rd(REG_COEF_D, td ? kco(td, ts) : 0);
		end
		for (int i = 0; i < 4; i++) wr(REG_LIM_HH + 5'(i), lim[i]);
		wr(REG_RATE_LIM, lim[4]);
		wr(REG_DEV_MINOR, lim[5]);
		wr(REG_DEV_MAJOR, lim[6]);
		wr(REG_HYST, hy);
		wr(REG_MANUAL, man);
		wr(REG_OUT_MIN, 32'h0100);
		wr(REG_OUT_MAX, 32'h4095);
		settg(32'h2000);
		// A random walk keeps the measured value wandering through the thresholds and their hysteresis bands.
		tick(32'h2000, 0);
		for (int i = 0; i < 40; i++) tick(c01(p1 + rn(-32'h400, 32'h800)), 0);
		par(32'h4000, 1, 1, 1);
		ctrl(32'h41);
		rd(REG_TARGET, tg);
		rd(REG_BIAS, mx);
		ctrl(0);
		ctrl(1);
		rd(REG_TARGET, tg);
		for (int i = 0; i < 8; i++) tick(rn(tg - 32'h80, 32'h100), 0);
		ctrl(2);
		for (int i = 0; i < 4; i++) tick(rn(p1 - 32'h40, 32'h80), rn(p1 - 32'h80, 32'h100));
		ctrl(3);
		rd(REG_CTRL, 2);
		ctrl(1);
		settg(32'h4000);
		tick(0, 0);
		rd(REG_BIAS, mx);
		chk("output_code", 16'(output_code), 16'd4095);
		ctrl(32'h09);
		tick(32'h4000, 0);
		@(posedge mclk);
		#1 chk("output_code", 16'(output_code), 16'd100);
		rd(REG_BIAS, mx);
		ctrl(32'h11);
		wr(REG_BIAS, 32'h5000);
		rd(REG_BIAS, ONE);
		mx = 32'h2000;
		wr(REG_BIAS, mx);
		settg(32'h2000);
		rd(REG_BIAS, mx);
		ctrl(32'h31);
		settg(32'h4000);
		rd(REG_BIAS, mx);
		par(32'h4000, 1, 9999, 0);
		ctrl(32'h21);
		for (int i = 0; i < 4; i++) tick(rn(32'h3000, 32'h1000), 0);
		ctrl(32'h05);
		for (int i = 0; i < 6; i++) tick(rn(32'h3800, 32'h800), 0);
		wr(REG_OUTPUT, 32'h1234);
		rd(REG_OUTPUT, o);
		tally_and_finish();
	end
endmodule
